// ===== dv/host_mcu_model.sv
`timescale 1ns/1ns
module host_mcu_model (
	input  wire       core_clk_i, // Clock
	input  wire [7:0] rdata_i,    // Read data
	output reg  [7:0] addr_o,     // Address
	output reg        wr_o,       // Write strobe
	output reg        rd_o,       // Read strobe
	output reg  [7:0] wdata_o     // Write data
);
	// Idle bus at time zero
	initial
	begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end
	// Strobe stands one cycle, taken at the next edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge core_clk_i);
		wr_o <= 1'b0;
	endtask
	// Data is registered, so look just after the taking edge
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge core_clk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask
endmodule

// ===== dv/pmic_irq_manager_properties.sv
`timescale 1ns/1ns
module pmic_irq_manager_properties (
	input wire       core_clk_i,         // Clock
	input wire       sys_rst_i,          // Reset
	input wire       ce_i,               // Enable
	input wire [7:0] reg_addr_i,         // Address
	input wire       reg_wr_i,           // Write
	input wire       reg_rd_i,           // Read
	input wire [7:0] reg_wdata_i,        // Write data
	input wire [7:0] reg_rdata_o,        // Read data
	input wire [7:0] pwr_btn_evt_i,      // Button events
	input wire [7:0] pwr_btn_sense_i,    // Button levels
	input wire       early_warn_i,       // Warning
	input wire       irq_out_n_o,        // Interrupt
	input wire [7:0] summary_register_o  // Summary
);
	reg [7:0] pbm_q;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Shadow of the button mask, since the checker cannot see it
	always @(posedge core_clk_i or posedge sys_rst_i)
		if (sys_rst_i)
			pbm_q <= 8'hff;
		else if (ce_i && reg_wr_i && reg_addr_i == 8'h1d)
			pbm_q <= reg_wdata_i;
	// Steady level long enough to pass the synchroniser
	sequence sns_steady;
		($stable(pwr_btn_sense_i) && ce_i)[*3];
	endsequence
	sequence btn_clear;
		ce_i && reg_wr_i && reg_addr_i == 8'h1c && reg_wdata_i == 8'hff && pwr_btn_evt_i == 8'h00;
	endsequence
	a_warn_flag: assert property ($past(ce_i) |-> summary_register_o[7] == $past(early_warn_i))
		else $error("warning flag wrong");
	a_irq_or_flags: assert property (irq_out_n_o == ~|summary_register_o)
		else $error("irq disagrees with summary");
	a_unmapped_read: assert property (ce_i && reg_rd_i && reg_addr_i > 8'h1e |=>
		reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	a_rdata_holds: assert property (!(ce_i && reg_rd_i) |=> $stable(reg_rdata_o))
		else $error("read data moved");
	a_button_raises: assert property ((ce_i && !reg_wr_i && pwr_btn_evt_i[0] && !pbm_q[0])
		##1 ce_i |-> ##1 (summary_register_o[6] && !irq_out_n_o)) else $error("button not flagged");
	a_button_flag_clear: assert property ($fell(summary_register_o[6]) |->
		$past(ce_i && reg_wr_i && (reg_addr_i == 8'h1c || reg_addr_i == 8'h1d), 2))
		else $error("button flag fell alone");
	a_sense_read: assert property (sns_steady ##0 (ce_i && reg_rd_i && reg_addr_i == 8'h1e)
		|=> reg_rdata_o == ($past(pwr_btn_sense_i) & 8'h81)) else $error("sense read wrong");
	a_cleared_reads_zero: assert property (btn_clear ##1 pwr_btn_evt_i == 8'h00
		##1 (ce_i && reg_rd_i && reg_addr_i == 8'h1c) |=> reg_rdata_o == 8'h00)
		else $error("latch not cleared");
endmodule
bind pmic_irq_manager pmic_irq_manager_properties chk_i (.core_clk_i, .sys_rst_i, .ce_i,
	.reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .pwr_btn_evt_i,
	.pwr_btn_sense_i, .early_warn_i, .irq_out_n_o, .summary_register_o);

// ===== dv/pmic_two_level_interrupt_manager_bench.sv
`timescale 1ns/1ns
module pmic_two_level_interrupt_manager_bench;
	reg core_clk_i = 1'b0;
	reg sys_rst_i = 1'b1;
	reg ce_i = 1'b1;
	reg early_warn_i = 1'b0;
	reg [7:0] sn = 8'h00;
	reg [7:0] ev [0:9];
	wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, summary_register_o;
	wire reg_wr_i, reg_rd_i, irq_out_n_o;
	logic [7:0] vld [0:9] = '{8'hff, 8'hff, 8'h73, 8'h73, 8'h07, 8'h73, 8'h73, 8'h07, 8'h07, 8'hff};
	logic [7:0] sv [0:9] = '{8'h07, 8'hff, 8'h00, 8'h73, 8'h07, 8'h73, 8'h73, 8'h07, 8'h07, 8'h81};
	int sb [0:9] = '{0, 1, 2, 3, 3, 4, 5, 4, 5, 6};
	int bad_count = 0;
	int check_count = 0;
	logic [7:0] rv;
	initial forever #4 core_clk_i = ~core_clk_i;
	host_mcu_model host (.core_clk_i(core_clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
		.wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));
	// Clock enable driven so the freeze can be checked
	pmic_irq_manager dut (.core_clk_i, .sys_rst_i, .ce_i, .reg_addr_i, .reg_wr_i,
		.reg_rd_i, .reg_wdata_i, .reg_rdata_o, .general_evt_i(ev[0]), .thermal_evt_i(ev[1]),
		.buck_set_evt_i(ev[2]), .buck_ilim_evt_i(ev[3]), .lin_ilim_evt_i(ev[4]),
		.buck_uv_evt_i(ev[5]), .buck_ov_evt_i(ev[6]), .lin_uv_evt_i(ev[7]), .lin_ov_evt_i(ev[8]),
		.pwr_btn_evt_i(ev[9]), .general_sense_i(sn), .thermal_sense_i(sn),
		.buck_ilim_sense_i(sn), .lin_ilim_sense_i(sn), .buck_uv_sense_i(sn),
		.buck_ov_sense_i(sn), .lin_uv_sense_i(sn), .lin_ov_sense_i(sn), .pwr_btn_sense_i(sn),
		.early_warn_i, .irq_out_n_o, .summary_register_o);
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task rchk(input string n, input int a, input logic [7:0] e);
		host.rd(8'(a), rv);
		chk(n, rv, e);
	endtask
	// Flags and pin settle two edges after their cause
	task fchk(input logic [7:0] e);
		wt(3);
		chk("summary", summary_register_o, e);
		chk("irq", {7'h00, irq_out_n_o}, {7'h00, e == 8'h00});
		rchk("summary read", 0, e);
	endtask
	// One-cycle event pulse on the selected groups
	task pulse(input logic [9:0] sel);
		@(posedge core_clk_i);
		for (int i = 0; i < 10; i++)
			ev[i] <= sel[i] ? 8'hff : 8'h00;
		@(posedge core_clk_i);
		for (int i = 0; i < 10; i++)
			ev[i] <= 8'h00;
	endtask
	// Reset values and an unmapped read
	task t_reset;
		rchk("unmapped", 8'h40, 8'h00);
		for (int g = 0; g < 10; g++)
		begin
			rchk("latch", 1 + 3 * g, 8'h00);
			rchk("mask", 2 + 3 * g, vld[g]);
		end
		fchk(8'h00);
	endtask
	// Masked events still latch but stay off the pin
	task t_masked;
		pulse(10'h3ff);
		fchk(8'h00);
		for (int g = 0; g < 10; g++)
		begin
			rchk("latch", 1 + 3 * g, vld[g]);
			host.wr(8'(1 + 3 * g), 8'hff);
			rchk("masked clear", 1 + 3 * g, 8'h00);
		end
	endtask
	// Each group alone: flag position, inert zero write, clear
	task t_groups;
		for (int g = 0; g < 10; g++)
		begin
			host.wr(8'(2 + 3 * g), 8'h00);
			pulse(10'h001 << g);
			fchk(8'h01 << sb[g]);
			host.wr(8'(1 + 3 * g), 8'h00);
			rchk("zero write", 1 + 3 * g, vld[g]);
			host.wr(8'(1 + 3 * g), 8'hff);
			rchk("cleared", 1 + 3 * g, 8'h00);
			fchk(8'h00);
			host.wr(8'(2 + 3 * g), 8'hff);
		end
	endtask
	// Live levels; writes to read-only places do nothing
	task t_sense;
		for (int p = 0; p < 2; p++)
		begin
			@(posedge core_clk_i);
			sn <= p ? 8'h5a : 8'hff;
			wt(4);
			host.wr(8'h1e, 8'h00);
			host.wr(8'h00, 8'hff);
			for (int g = 0; g < 10; g++)
				rchk("sense", 3 + 3 * g, sn & sv[g]);
			fchk(8'h00);
		end
	endtask
	// Warning drives bit 7 with no latch behind it
	task t_warn;
		@(posedge core_clk_i);
		early_warn_i <= 1'b1;
		fchk(8'h80);
		@(posedge core_clk_i);
		early_warn_i <= 1'b0;
		fchk(8'h00);
	endtask
	// Event and one-write clear in one cycle: the event wins
	task t_collide;
		fork
			host.wr(8'h01, 8'hff);
			pulse(10'h001);
		join
		rchk("set wins", 1, 8'hff);
		host.wr(8'h01, 8'hff);
		rchk("collide clear", 1, 8'h00);
	endtask
	// Clock enable low: an unmasked event is not taken
	task t_freeze;
		host.wr(8'h02, 8'h00);
		@(posedge core_clk_i);
		ce_i <= 1'b0;
		pulse(10'h001);
		wt(2);
		chk("frozen summary", summary_register_o, 8'h00);
		@(posedge core_clk_i);
		ce_i <= 1'b1;
		fchk(8'h00);
		rchk("frozen latch", 1, 8'h00);
		host.wr(8'h02, 8'hff);
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		for (int i = 0; i < 10; i++)
			ev[i] = 8'h00;
		repeat (8) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		wt(1);
		t_reset;
		t_masked;
		t_groups;
		t_sense;
		t_warn;
		t_collide;
		t_freeze;
		end_of_test;
	end
	// Cuts a hung run short
	initial
	begin
		repeat (20000) @(posedge core_clk_i);
		bad_count++;
		end_of_test;
	end
endmodule

// ===== src/event_latch_group.v
`timescale 1ns/1ns
`include "irq_mgr_defs.vh"

module event_latch_group #(
	parameter [7:0] VALID    = 8'hff,
	parameter [7:0] MASK_RST = 8'hff
) (
	input  wire       core_clk_i,   // Core clock
	input  wire       sys_rst_i,    // Async reset, active high
	input  wire       ce_i,         // Clock enable
	input  wire [7:0] evt_i,        // Event pulses, one bit per latch
	input  wire       latch_we_i,   // Write strobe to latch register
	input  wire       mask_we_i,    // Write strobe to mask register
	input  wire [7:0] wdata_i,      // Write data
	output reg  [7:0] latch_q_o,    // Latched events
	output reg  [7:0] mask_q_o,     // Mask bits
	output wire       pending_o     // Any unmasked latch set
);

	reg [7:0] latch_d;
	reg [7:0] mask_d;

	// Clear by one, event set wins so a coincident event is never lost
	always @*
	begin
		latch_d = latch_q_o;
		if (latch_we_i)
			latch_d = latch_q_o & ~wdata_i;
		latch_d = (latch_d | evt_i) & VALID;
		mask_d = mask_q_o;
		if (mask_we_i)
			mask_d = (wdata_i & VALID) | ~VALID;            // Unused bits stay masked
	end

	// State, frozen while clock enable is low
	always @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			latch_q_o <= `RST_LATCH;
			mask_q_o  <= MASK_RST;
		end
		else if (ce_i)
		begin
			latch_q_o <= latch_d;
			mask_q_o  <= mask_d;
		end
	end

	// Masked latches still record, they just stay off the pin
	assign pending_o = |(latch_q_o & ~mask_q_o);

endmodule

// ===== src/irq_mgr_defs.vh
`ifndef IRQ_MGR_DEFS_VH
`define IRQ_MGR_DEFS_VH

// Register port geometry
`define ADDR_W            8
`define DATA_W            8
`define GROUP_CNT         10

// Group indices, also the order of the packed group buses
`define GRP_GENERAL       0
`define GRP_THERMAL       1
`define GRP_BUCK_SET      2
`define GRP_BUCK_ILIM     3
`define GRP_LIN_ILIM      4
`define GRP_BUCK_UV       5
`define GRP_BUCK_OV       6
`define GRP_LIN_UV        7
`define GRP_LIN_OV        8
`define GRP_PWR_BTN       9

// Register offsets: each group owns latch, mask, sense in that order
`define OFS_SUMMARY_FLAGS 8'h00
`define OFS_GROUP_BASE    8'h01
`define OFS_GROUP_STRIDE  8'h03
`define OFS_MASK_DELTA    8'h01
`define OFS_SENSE_DELTA   8'h02

// Implemented latch and mask bits per group
`define VLD_GENERAL       8'hff
`define VLD_THERMAL       8'hff
`define VLD_BUCK          8'h73
`define VLD_LINEAR        8'h07
`define VLD_PWR_BTN       8'hff

// Implemented live sense bits per group
`define SNS_GENERAL       8'h07
`define SNS_THERMAL       8'hff
`define SNS_NONE          8'h00
`define SNS_BUCK          8'h73
`define SNS_LINEAR        8'h07
`define SNS_PWR_BTN       8'h81

// Reset values
`define RST_LATCH         8'h00
`define RST_MASK          8'hff
`define RST_RDATA         8'h00

// Summary flag positions
`define SUM_GENERAL       0
`define SUM_THERMAL       1
`define SUM_BUCK_SET      2
`define SUM_ILIM          3
`define SUM_UV            4
`define SUM_OV            5
`define SUM_PWR_BTN       6
`define SUM_EARLY_WARN    7

`endif

// ===== src/pmic_irq_manager.v
// Overview of operation
// - Latch sets on event, clears on one-write
// - Masked latch never affects interrupt output
// - Unmasked set latch holds interrupt low
// - Sense read returns live source state
// - Interrupt is OR of unmasked latches and early warning
// - Summary bit set by unmasked group latch
// - Summary bit clears itself with latches
// - Interrupt held while any summary bit set
// - Summary bits 0,1,2,6 map single groups
// - Bits 3,4,5 merge buck and linear groups
// - Bit 7 follows early shutdown warning
`timescale 1ns/1ns
`include "irq_mgr_defs.vh"

module pmic_irq_manager (
	input  wire                core_clk_i,          // 125 MHz core clock
	input  wire                sys_rst_i,           // Async reset, active high
	input  wire                ce_i,                // Clock enable, freezes state when low
	input  wire [`ADDR_W-1:0]  reg_addr_i,          // Register address
	input  wire                reg_wr_i,            // Register write strobe
	input  wire                reg_rd_i,            // Register read strobe
	input  wire [`DATA_W-1:0]  reg_wdata_i,         // Register write data
	output reg  [`DATA_W-1:0]  reg_rdata_o,         // Register read data
	input  wire [7:0]          general_evt_i,       // General status event pulses
	input  wire [7:0]          thermal_evt_i,       // Thermal and watchdog event pulses
	input  wire [7:0]          buck_set_evt_i,      // Buck setting change pulses
	input  wire [7:0]          buck_ilim_evt_i,     // Buck current limit pulses
	input  wire [7:0]          lin_ilim_evt_i,      // Linear current limit pulses
	input  wire [7:0]          buck_uv_evt_i,       // Buck undervoltage pulses
	input  wire [7:0]          buck_ov_evt_i,       // Buck overvoltage pulses
	input  wire [7:0]          lin_uv_evt_i,        // Linear undervoltage pulses
	input  wire [7:0]          lin_ov_evt_i,        // Linear overvoltage pulses
	input  wire [7:0]          pwr_btn_evt_i,       // Power button event pulses
	input  wire [7:0]          general_sense_i,     // General live levels, async
	input  wire [7:0]          thermal_sense_i,     // Thermal live levels, async
	input  wire [7:0]          buck_ilim_sense_i,   // Buck current limit levels, async
	input  wire [7:0]          lin_ilim_sense_i,    // Linear current limit levels, async
	input  wire [7:0]          buck_uv_sense_i,     // Buck undervoltage levels, async
	input  wire [7:0]          buck_ov_sense_i,     // Buck overvoltage levels, async
	input  wire [7:0]          lin_uv_sense_i,      // Linear undervoltage levels, async
	input  wire [7:0]          lin_ov_sense_i,      // Linear overvoltage levels, async
	input  wire [7:0]          pwr_btn_sense_i,     // Power button live levels, async
	input  wire                early_warn_i,        // Early shutdown warning level
	output reg                 irq_out_n_o,         // Interrupt to host, active low
	output reg  [7:0]          summary_register_o   // Summary flags, registered copy
);

	localparam NG = `GROUP_CNT;

	// Implemented latch bits of a group
	function [7:0] grp_valid;
		input integer g;
		begin
			case (g)
				`GRP_GENERAL:  grp_valid = `VLD_GENERAL;
				`GRP_THERMAL:  grp_valid = `VLD_THERMAL;
				`GRP_BUCK_SET,
				`GRP_BUCK_ILIM,
				`GRP_BUCK_UV,
				`GRP_BUCK_OV:  grp_valid = `VLD_BUCK;
				`GRP_PWR_BTN:  grp_valid = `VLD_PWR_BTN;
				default:       grp_valid = `VLD_LINEAR;
			endcase
		end
	endfunction

	// Implemented sense bits of a group; none for buck setting change
	function [7:0] grp_sense_valid;
		input integer g;
		begin
			case (g)
				`GRP_GENERAL:  grp_sense_valid = `SNS_GENERAL;
				`GRP_THERMAL:  grp_sense_valid = `SNS_THERMAL;
				`GRP_BUCK_SET: grp_sense_valid = `SNS_NONE;
				`GRP_BUCK_ILIM,
				`GRP_BUCK_UV,
				`GRP_BUCK_OV:  grp_sense_valid = `SNS_BUCK;
				`GRP_PWR_BTN:  grp_sense_valid = `SNS_PWR_BTN;
				default:       grp_sense_valid = `SNS_LINEAR;
			endcase
		end
	endfunction

	// Address of a group's latch register
	function [7:0] grp_base;
		input integer g;
		begin
			grp_base = `OFS_GROUP_BASE + g[7:0] * `OFS_GROUP_STRIDE;
		end
	endfunction

	// Packed group buses, group g occupies bits [8g+7:8g]
	wire [8*NG-1:0] sense_raw;
	wire [8*NG-1:0] latch_all;
	wire [8*NG-1:0] mask_all;
	wire [NG-1:0]   pend_all;

	// Buck setting change has no sense register, its slot reads zero
	assign sense_raw = {pwr_btn_sense_i, lin_ov_sense_i, lin_uv_sense_i,
		buck_ov_sense_i, buck_uv_sense_i, lin_ilim_sense_i, buck_ilim_sense_i,
		8'h00, thermal_sense_i, general_sense_i};

	// Two-flop synchroniser for the asynchronous live levels
	reg [8*NG-1:0] sense_meta_q;
	reg [8*NG-1:0] sense_sync_q;

	always @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			sense_meta_q <= {(8*NG){1'b0}};
			sense_sync_q <= {(8*NG){1'b0}};
		end
		else if (ce_i)
		begin
			sense_meta_q <= sense_raw;
			sense_sync_q <= sense_meta_q;
		end
	end

	// Write strobes stay combinational so a write lands on the edge it is taken
	wire [NG-1:0] lat_we;
	wire [NG-1:0] msk_we;
	genvar gi;
	generate
		for (gi = 0; gi < NG; gi = gi + 1)
		begin : g_dec
			assign lat_we[gi] = reg_wr_i && (reg_addr_i == grp_base(gi));
			assign msk_we[gi] = reg_wr_i && (reg_addr_i == grp_base(gi) + `OFS_MASK_DELTA);
		end
	endgenerate

	// General status group, all eight bits implemented
	event_latch_group #(
		.VALID    (`VLD_GENERAL),
		.MASK_RST (`RST_MASK)
	) u_general (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.evt_i      (general_evt_i),
		.latch_we_i (lat_we[`GRP_GENERAL]),
		.mask_we_i  (msk_we[`GRP_GENERAL]),
		.wdata_i    (reg_wdata_i),
		.latch_q_o  (latch_all[8*`GRP_GENERAL +: 8]),
		.mask_q_o   (mask_all[8*`GRP_GENERAL +: 8]),
		.pending_o  (pend_all[`GRP_GENERAL])
	);

	// Thermal and watchdog group, reported as the second general flag
	event_latch_group #(
		.VALID    (`VLD_THERMAL),
		.MASK_RST (`RST_MASK)
	) u_thermal (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.evt_i      (thermal_evt_i),
		.latch_we_i (lat_we[`GRP_THERMAL]),
		.mask_we_i  (msk_we[`GRP_THERMAL]),
		.wdata_i    (reg_wdata_i),
		.latch_q_o  (latch_all[8*`GRP_THERMAL +: 8]),
		.mask_q_o   (mask_all[8*`GRP_THERMAL +: 8]),
		.pending_o  (pend_all[`GRP_THERMAL])
	);

	// Buck setting change group, no live levels behind it
	event_latch_group #(
		.VALID    (`VLD_BUCK),
		.MASK_RST (`RST_MASK)
	) u_buck_set (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.evt_i      (buck_set_evt_i),
		.latch_we_i (lat_we[`GRP_BUCK_SET]),
		.mask_we_i  (msk_we[`GRP_BUCK_SET]),
		.wdata_i    (reg_wdata_i),
		.latch_q_o  (latch_all[8*`GRP_BUCK_SET +: 8]),
		.mask_q_o   (mask_all[8*`GRP_BUCK_SET +: 8]),
		.pending_o  (pend_all[`GRP_BUCK_SET])
	);

	// Buck current limit group, shares its flag with the linear one
	event_latch_group #(
		.VALID    (`VLD_BUCK),
		.MASK_RST (`RST_MASK)
	) u_buck_ilim (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.evt_i      (buck_ilim_evt_i),
		.latch_we_i (lat_we[`GRP_BUCK_ILIM]),
		.mask_we_i  (msk_we[`GRP_BUCK_ILIM]),
		.wdata_i    (reg_wdata_i),
		.latch_q_o  (latch_all[8*`GRP_BUCK_ILIM +: 8]),
		.mask_q_o   (mask_all[8*`GRP_BUCK_ILIM +: 8]),
		.pending_o  (pend_all[`GRP_BUCK_ILIM])
	);

	// Linear current limit group, three regulators only
	event_latch_group #(
		.VALID    (`VLD_LINEAR),
		.MASK_RST (`RST_MASK)
	) u_lin_ilim (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.evt_i      (lin_ilim_evt_i),
		.latch_we_i (lat_we[`GRP_LIN_ILIM]),
		.mask_we_i  (msk_we[`GRP_LIN_ILIM]),
		.wdata_i    (reg_wdata_i),
		.latch_q_o  (latch_all[8*`GRP_LIN_ILIM +: 8]),
		.mask_q_o   (mask_all[8*`GRP_LIN_ILIM +: 8]),
		.pending_o  (pend_all[`GRP_LIN_ILIM])
	);

	// Buck undervoltage group
	event_latch_group #(
		.VALID    (`VLD_BUCK),
		.MASK_RST (`RST_MASK)
	) u_buck_uv (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.evt_i      (buck_uv_evt_i),
		.latch_we_i (lat_we[`GRP_BUCK_UV]),
		.mask_we_i  (msk_we[`GRP_BUCK_UV]),
		.wdata_i    (reg_wdata_i),
		.latch_q_o  (latch_all[8*`GRP_BUCK_UV +: 8]),
		.mask_q_o   (mask_all[8*`GRP_BUCK_UV +: 8]),
		.pending_o  (pend_all[`GRP_BUCK_UV])
	);

	// Buck overvoltage group
	event_latch_group #(
		.VALID    (`VLD_BUCK),
		.MASK_RST (`RST_MASK)
	) u_buck_ov (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.evt_i      (buck_ov_evt_i),
		.latch_we_i (lat_we[`GRP_BUCK_OV]),
		.mask_we_i  (msk_we[`GRP_BUCK_OV]),
		.wdata_i    (reg_wdata_i),
		.latch_q_o  (latch_all[8*`GRP_BUCK_OV +: 8]),
		.mask_q_o   (mask_all[8*`GRP_BUCK_OV +: 8]),
		.pending_o  (pend_all[`GRP_BUCK_OV])
	);

	// Linear undervoltage group
	event_latch_group #(
		.VALID    (`VLD_LINEAR),
		.MASK_RST (`RST_MASK)
	) u_lin_uv (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.evt_i      (lin_uv_evt_i),
		.latch_we_i (lat_we[`GRP_LIN_UV]),
		.mask_we_i  (msk_we[`GRP_LIN_UV]),
		.wdata_i    (reg_wdata_i),
		.latch_q_o  (latch_all[8*`GRP_LIN_UV +: 8]),
		.mask_q_o   (mask_all[8*`GRP_LIN_UV +: 8]),
		.pending_o  (pend_all[`GRP_LIN_UV])
	);

	// Linear overvoltage group
	event_latch_group #(
		.VALID    (`VLD_LINEAR),
		.MASK_RST (`RST_MASK)
	) u_lin_ov (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.evt_i      (lin_ov_evt_i),
		.latch_we_i (lat_we[`GRP_LIN_OV]),
		.mask_we_i  (msk_we[`GRP_LIN_OV]),
		.wdata_i    (reg_wdata_i),
		.latch_q_o  (latch_all[8*`GRP_LIN_OV +: 8]),
		.mask_q_o   (mask_all[8*`GRP_LIN_OV +: 8]),
		.pending_o  (pend_all[`GRP_LIN_OV])
	);

	// Power button group, fed by the debounced button events
	event_latch_group #(
		.VALID    (`VLD_PWR_BTN),
		.MASK_RST (`RST_MASK)
	) u_pwr_btn (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.evt_i      (pwr_btn_evt_i),
		.latch_we_i (lat_we[`GRP_PWR_BTN]),
		.mask_we_i  (msk_we[`GRP_PWR_BTN]),
		.wdata_i    (reg_wdata_i),
		.latch_q_o  (latch_all[8*`GRP_PWR_BTN +: 8]),
		.mask_q_o   (mask_all[8*`GRP_PWR_BTN +: 8]),
		.pending_o  (pend_all[`GRP_PWR_BTN])
	);

	// First level flags follow the groups live, so clearing the
	// second level drops them with no write to the summary
	wire [7:0] summary_d;

	assign summary_d[`SUM_GENERAL]    = pend_all[`GRP_GENERAL];
	assign summary_d[`SUM_THERMAL]    = pend_all[`GRP_THERMAL];
	assign summary_d[`SUM_BUCK_SET]   = pend_all[`GRP_BUCK_SET];
	assign summary_d[`SUM_ILIM]       = pend_all[`GRP_BUCK_ILIM] | pend_all[`GRP_LIN_ILIM];
	assign summary_d[`SUM_UV]         = pend_all[`GRP_BUCK_UV] | pend_all[`GRP_LIN_UV];
	assign summary_d[`SUM_OV]         = pend_all[`GRP_BUCK_OV] | pend_all[`GRP_LIN_OV];
	assign summary_d[`SUM_PWR_BTN]    = pend_all[`GRP_PWR_BTN];
	assign summary_d[`SUM_EARLY_WARN] = early_warn_i;

	// Register read mux; unmapped or absent bits read zero
	reg [7:0] rdata_d;
	integer   g;

	always @*
	begin
		rdata_d = `RST_RDATA;
		if (reg_addr_i == `OFS_SUMMARY_FLAGS)
			rdata_d = summary_d;
		for (g = 0; g < NG; g = g + 1)
		begin
			if (reg_addr_i == grp_base(g))
				rdata_d = latch_all[8*g +: 8];
			if (reg_addr_i == grp_base(g) + `OFS_MASK_DELTA)
				rdata_d = mask_all[8*g +: 8] & grp_valid(g);
			if (reg_addr_i == grp_base(g) + `OFS_SENSE_DELTA)
				rdata_d = sense_sync_q[8*g +: 8] & grp_sense_valid(g);
		end
	end

	// Output flops; reads have no side effect on any latch
	always @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			reg_rdata_o        <= `RST_RDATA;
			irq_out_n_o        <= 1'b1;
			summary_register_o <= 8'h00;
		end
		else if (ce_i)
		begin
			if (reg_rd_i)
				reg_rdata_o <= rdata_d;
			summary_register_o <= summary_d;
			irq_out_n_o        <= ~(|summary_d);
		end
	end

	// Writes to summary and sense offsets decode to no strobe at all,
	// so they fall through harmlessly

endmodule
